// file: src/pirf_defines.svh
`ifndef PIRF_DEFINES_SVH
`define PIRF_DEFINES_SVH

// ==========================================================
// register map
`define PIRF_ADDR_W       8
`define PIRF_DATA_W       8
`define PIRF_FLAGS_OFS    8'h0C
`define PIRF_FLAGS_RST    8'h00
`define PIRF_WR_MASK      8'hCF
`define PIRF_RDATA_IDLE   8'h00

// ==========================================================
// field positions
`define PIRF_BIT_PSP      7
`define PIRF_BIT_CONV     6
`define PIRF_BIT_RX       5
`define PIRF_BIT_TX       4
`define PIRF_BIT_SSP      3
`define PIRF_BIT_CCP      2
`define PIRF_BIT_PER      1
`define PIRF_BIT_OVF      0

`endif

// file: src/pirf_pkg.sv
package pirf_pkg;

  // ==========================================================
  // bus and event carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pirf_bus_req_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic xfer;
    logic ack;
    logic restart;
  } pirf_ssp_evt_t;

  typedef struct packed {
    logic compare_mode;
    logic capture;
    logic match;
  } pirf_ccp_evt_t;

  // ==========================================================
  // module state
  typedef struct packed {
    logic flag;
  } pirf_cell_state_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rx_mirror;
  } pirf_main_state_t;

endpackage : pirf_pkg

// file: src/pirf_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pirf_flag_cell (
  input  wire logic i_clock,  // core clock
  input  wire logic i_rstn,   // sync reset, active low
  input  wire logic i_set,    // hardware event pulse
  input  wire logic i_wr,     // software write of this bit
  input  wire logic i_wdata,  // written value
  output logic      o_flag    // sticky flag
);
  pirf_pkg::pirf_cell_state_t state_reg;
  pirf_pkg::pirf_cell_state_t state_next;

  // ==========================================================
  // sticky flag, hardware set beats software clear
  always_comb begin
    state_next = state_reg;
    if (i_wr) begin
      state_next.flag = i_wdata;
    end
    if (i_set) begin
      state_next.flag = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_flag = state_reg.flag;

endmodule : pirf_flag_cell
`default_nettype wire

// file: src/pirf_tx_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module pirf_tx_tracker (
  input  wire logic i_clock,   // core clock
  input  wire logic i_rstn,    // sync reset, active low
  input  wire logic i_moved,   // holding word moved to shift register
  input  wire logic i_loaded,  // holding buffer written again
  output logic      o_flag     // holding buffer empty flag
);
  pirf_pkg::pirf_cell_state_t state_reg;
  pirf_pkg::pirf_cell_state_t state_next;

  // ==========================================================
  // set on transfer, cleared only by a refill, never by software
  always_comb begin
    state_next = state_reg;
    if (i_loaded) begin
      state_next.flag = 1'b0;
    end
    if (i_moved) begin
      state_next.flag = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_flag = state_reg.flag;

endmodule : pirf_tx_tracker
`default_nettype wire

// file: src/pirf_flag_register.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pirf_defines.svh"
module pirf_flag_register (
  input  wire logic                  i_clock,         // core clock, 50 MHz
  input  wire logic                  i_rstn,          // sync reset, active low
  input  wire pirf_pkg::pirf_bus_req_t i_bus,         // register bus request
  input  wire logic                  i_psp_done,      // parallel port access completed
  input  wire logic                  i_conv_done,     // conversion finished
  input  wire logic                  i_rx_full,       // receive buffer holds data
  input  wire logic                  i_tx_moved,      // transmit word moved to shift register
  input  wire logic                  i_tx_loaded,     // transmit holding buffer refilled
  input  wire pirf_pkg::pirf_ssp_evt_t i_ssp,         // sync serial events
  input  wire pirf_pkg::pirf_ccp_evt_t i_ccp,         // capture/compare events
  input  wire logic                  i_period_match,  // timer period match
  input  wire logic                  i_overflow,      // counter overflow
  output logic [7:0]                 o_rdata,         // read data, cycle after read
  output logic [7:0]                 o_flags          // current flags
);

  localparam logic [7:0] WR_MASK = `PIRF_WR_MASK;

  pirf_pkg::pirf_main_state_t state_reg;
  pirf_pkg::pirf_main_state_t state_next;

  logic [7:0] flags;
  logic [7:0] set_vec;
  logic       flag_hit;
  logic       flag_wr;
  logic       flag_rd;

  // ==========================================================
  // decode helpers
  function automatic logic pirf_hit(input logic [7:0] addr);
    pirf_hit = (addr == `PIRF_FLAGS_OFS);
  endfunction : pirf_hit

  function automatic logic pirf_ssp_any(input pirf_pkg::pirf_ssp_evt_t e);
    pirf_ssp_any = e.start | e.stop | e.xfer | e.ack | e.restart;
  endfunction : pirf_ssp_any

  function automatic logic pirf_ccp_any(input pirf_pkg::pirf_ccp_evt_t e);
    pirf_ccp_any = e.compare_mode ? e.match : e.capture;
  endfunction : pirf_ccp_any

  assign flag_hit = pirf_hit(i_bus.addr);
  assign flag_wr  = i_bus.wr & flag_hit;
  assign flag_rd  = i_bus.rd & flag_hit;

  // ==========================================================
  // event gathering, no enable gating
  always_comb begin
    set_vec                 = '0;
    set_vec[`PIRF_BIT_PSP]  = i_psp_done;
    set_vec[`PIRF_BIT_CONV] = i_conv_done;
    set_vec[`PIRF_BIT_SSP]  = pirf_ssp_any(i_ssp);
    set_vec[`PIRF_BIT_CCP]  = pirf_ccp_any(i_ccp);
    set_vec[`PIRF_BIT_PER]  = i_period_match;
    set_vec[`PIRF_BIT_OVF]  = i_overflow;
  end

  // ==========================================================
  // writable sticky flags
  for (genvar i = 0; i < 8; i++) begin : g_cell
    if (WR_MASK[i]) begin : g_rw
      pirf_flag_cell u_cell (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_set   (set_vec[i]),
        .i_wr    (flag_wr),
        .i_wdata (i_bus.wdata[i]),
        .o_flag  (flags[i])
      );
    end
  end

  // ==========================================================
  // read-only flags
  pirf_tx_tracker u_tx (
    .i_clock  (i_clock),
    .i_rstn   (i_rstn),
    .i_moved  (i_tx_moved),
    .i_loaded (i_tx_loaded),
    .o_flag   (flags[`PIRF_BIT_TX])
  );

  assign flags[`PIRF_BIT_RX] = state_reg.rx_mirror;

  // ==========================================================
  // state update and read port
  always_comb begin
    state_next           = state_reg;
    state_next.rx_mirror = i_rx_full;
    state_next.rdata     = `PIRF_RDATA_IDLE;
    if (flag_rd) begin
      state_next.rdata = flags;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_flags = flags;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock);
  endclocking

  default disable iff (!i_rstn);

  property p_psp_set;
    i_psp_done |=> o_flags[`PIRF_BIT_PSP];
  endproperty
  a_psp_set: assert property (p_psp_set)
    else $error("parallel port flag not set after access");

  property p_psp_clear;
    (flag_wr && !i_bus.wdata[`PIRF_BIT_PSP] && !i_psp_done) |=> !o_flags[`PIRF_BIT_PSP];
  endproperty
  a_psp_clear: assert property (p_psp_clear)
    else $error("parallel port flag not cleared by write");

  property p_conv_set;
    i_conv_done |=> o_flags[`PIRF_BIT_CONV];
  endproperty
  a_conv_set: assert property (p_conv_set)
    else $error("conversion flag not set");

  property p_rx_mirror;
    ##1 (o_flags[`PIRF_BIT_RX] == $past(i_rx_full));
  endproperty
  a_rx_mirror: assert property (p_rx_mirror)
    else $error("receive flag does not follow buffer");

  property p_tx_set;
    i_tx_moved |=> o_flags[`PIRF_BIT_TX] ##1 (o_flags[`PIRF_BIT_TX] || $past(i_tx_loaded));
  endproperty
  a_tx_set: assert property (p_tx_set)
    else $error("transmit flag not set or lost");

  property p_tx_ro;
    (flag_wr && !i_tx_moved && !i_tx_loaded) |=> $stable(o_flags[`PIRF_BIT_TX]);
  endproperty
  a_tx_ro: assert property (p_tx_ro)
    else $error("transmit flag changed by write");

  property p_ssp_set;
    (i_ssp.start || i_ssp.stop || i_ssp.xfer || i_ssp.ack || i_ssp.restart)
      |=> o_flags[`PIRF_BIT_SSP];
  endproperty
  a_ssp_set: assert property (p_ssp_set)
    else $error("sync serial flag not set");

  property p_ccp_set;
    ((i_ccp.compare_mode && i_ccp.match) || (!i_ccp.compare_mode && i_ccp.capture))
      |=> o_flags[`PIRF_BIT_CCP];
  endproperty
  a_ccp_set: assert property (p_ccp_set)
    else $error("capture/compare flag not set");

  property p_per_set;
    i_period_match |=> o_flags[`PIRF_BIT_PER];
  endproperty
  a_per_set: assert property (p_per_set)
    else $error("period match flag not set");

  property p_ovf_hold;
    (o_flags[`PIRF_BIT_OVF] && !(flag_wr && !i_bus.wdata[`PIRF_BIT_OVF]))
      |=> o_flags[`PIRF_BIT_OVF];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag dropped without a write");

  property p_ovf_set_wins;
    (i_overflow && flag_wr && !i_bus.wdata[`PIRF_BIT_OVF]) |=> o_flags[`PIRF_BIT_OVF];
  endproperty
  a_ovf_set_wins: assert property (p_ovf_set_wins)
    else $error("overflow event lost to clear");

  property p_read_data;
    flag_rd |=> (o_rdata == $past(o_flags)) ##1 (o_rdata == 8'h00 || $past(flag_rd));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data wrong or held too long");

  property p_ovf_set;
    i_overflow |=> o_flags[`PIRF_BIT_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set");

  property p_ovf_clear;
    (flag_wr && !i_bus.wdata[`PIRF_BIT_OVF] && !i_overflow) |=> !o_flags[`PIRF_BIT_OVF];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flag not cleared by write");

  property p_ovf_write_set;
    (flag_wr && i_bus.wdata[`PIRF_BIT_OVF]) |=> o_flags[`PIRF_BIT_OVF];
  endproperty
  a_ovf_write_set: assert property (p_ovf_write_set)
    else $error("overflow flag not set by write");

  property p_unmapped_write;
    (i_bus.wr && !flag_hit && !i_overflow) |=> (o_flags[`PIRF_BIT_OVF] == $past(o_flags[`PIRF_BIT_OVF]));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("write to another address changed a flag");

  property p_psp_hold;
    (o_flags[`PIRF_BIT_PSP] && !(flag_wr && !i_bus.wdata[`PIRF_BIT_PSP])) |=> o_flags[`PIRF_BIT_PSP];
  endproperty
  a_psp_hold: assert property (p_psp_hold)
    else $error("parallel port flag dropped without a write");

  property p_conv_clear;
    (flag_wr && !i_bus.wdata[`PIRF_BIT_CONV] && !i_conv_done) |=> !o_flags[`PIRF_BIT_CONV];
  endproperty
  a_conv_clear: assert property (p_conv_clear)
    else $error("conversion flag not cleared by write");

  property p_conv_hold;
    (o_flags[`PIRF_BIT_CONV] && !(flag_wr && !i_bus.wdata[`PIRF_BIT_CONV])) |=> o_flags[`PIRF_BIT_CONV];
  endproperty
  a_conv_hold: assert property (p_conv_hold)
    else $error("conversion flag dropped without a write");

  property p_ssp_clear;
    (flag_wr && !i_bus.wdata[`PIRF_BIT_SSP]
      && !(i_ssp.start || i_ssp.stop || i_ssp.xfer || i_ssp.ack || i_ssp.restart)) |=> !o_flags[`PIRF_BIT_SSP];
  endproperty
  a_ssp_clear: assert property (p_ssp_clear)
    else $error("sync serial flag not cleared by write");

  property p_ssp_hold;
    (o_flags[`PIRF_BIT_SSP] && !(flag_wr && !i_bus.wdata[`PIRF_BIT_SSP])) |=> o_flags[`PIRF_BIT_SSP];
  endproperty
  a_ssp_hold: assert property (p_ssp_hold)
    else $error("sync serial flag dropped without a write");

  property p_ccp_clear;
    (flag_wr && !i_bus.wdata[`PIRF_BIT_CCP]
      && !((i_ccp.compare_mode && i_ccp.match) || (!i_ccp.compare_mode && i_ccp.capture)))
      |=> !o_flags[`PIRF_BIT_CCP];
  endproperty
  a_ccp_clear: assert property (p_ccp_clear)
    else $error("capture/compare flag not cleared by write");

  property p_ccp_idle;
    (!o_flags[`PIRF_BIT_CCP] && !(flag_wr && i_bus.wdata[`PIRF_BIT_CCP])
      && !((i_ccp.compare_mode && i_ccp.match) || (!i_ccp.compare_mode && i_ccp.capture)))
      |=> !o_flags[`PIRF_BIT_CCP];
  endproperty
  a_ccp_idle: assert property (p_ccp_idle)
    else $error("capture/compare flag set by event of the other mode");

  property p_per_clear;
    (flag_wr && !i_bus.wdata[`PIRF_BIT_PER] && !i_period_match) |=> !o_flags[`PIRF_BIT_PER];
  endproperty
  a_per_clear: assert property (p_per_clear)
    else $error("period match flag not cleared by write");

  property p_per_hold;
    (o_flags[`PIRF_BIT_PER] && !(flag_wr && !i_bus.wdata[`PIRF_BIT_PER])) |=> o_flags[`PIRF_BIT_PER];
  endproperty
  a_per_hold: assert property (p_per_hold)
    else $error("period match flag dropped without a write");

  property p_rx_no_write;
    (flag_wr && i_bus.wdata[`PIRF_BIT_RX] && !i_rx_full) |=> !o_flags[`PIRF_BIT_RX];
  endproperty
  a_rx_no_write: assert property (p_rx_no_write)
    else $error("receive flag set by write");

  property p_tx_load;
    (i_tx_loaded && !i_tx_moved) |=> !o_flags[`PIRF_BIT_TX];
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("transmit flag not cleared by refill");

  property p_tx_idle;
    (!o_flags[`PIRF_BIT_TX] && !i_tx_moved) |=> !o_flags[`PIRF_BIT_TX];
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("transmit flag set without a transfer");

  property p_rdata_idle;
    !flag_rd |=> (o_rdata == `PIRF_RDATA_IDLE);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not idle without a read");

  property p_reset_state;
    @(posedge i_clock) disable iff (1'b0)
      !i_rstn |=> (o_flags == `PIRF_FLAGS_RST && o_rdata == `PIRF_RDATA_IDLE);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not cleared by reset");

endmodule : pirf_flag_register
`default_nettype wire

// file: testbench/pirf_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// peripherals raising events, one source per code
module pirf_periph_model (
  input  wire logic                   i_go,            // raise one event now
  input  wire logic [3:0]             i_code,          // event code 0 to 12
  input  wire logic                   i_rx_level,      // receive buffer holds data
  input  wire logic                   i_cmp_mode,      // capture unit in compare mode
  output logic                        o_psp_done,      // host access finished
  output logic                        o_conv_done,     // conversion finished
  output logic                        o_rx_full,       // receive level
  output logic                        o_tx_moved,      // holding word moved
  output logic                        o_tx_loaded,     // holding buffer refilled
  output var pirf_pkg::pirf_ssp_evt_t o_ssp,           // sync serial events
  output var pirf_pkg::pirf_ccp_evt_t o_ccp,           // capture/compare events
  output logic                        o_period_match,  // period match
  output logic                        o_overflow       // counter overflow
);
  logic [12:0] hot;
  assign hot = i_go ? (13'h0001 << i_code) : 13'h0000;
  assign o_psp_done = hot[0];
  assign o_conv_done = hot[1];
  assign o_tx_moved = hot[2];
  assign o_tx_loaded = hot[3];
  assign o_ssp = hot[8:4];
  assign o_ccp = {i_cmp_mode, hot[9], hot[10]};
  assign o_period_match = hot[11];
  assign o_overflow = hot[12];
  assign o_rx_full = i_rx_level;
endmodule : pirf_periph_model
`default_nettype wire

// file: testbench/pirf_flag_register_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pirf_flag_register_bench;
  logic                    i_clock;
  logic                    i_rstn;
  logic                    go;
  logic [3:0]              code;
  logic                    rx;
  logic                    cm;
  logic                    started;
  pirf_pkg::pirf_bus_req_t bus;
  logic [7:0]              exp_flags;
  logic [7:0]              exp_rdata;
  logic [7:0]              o_flags;
  logic [7:0]              o_rdata;
  logic                    psp, conv, rxf, txm, txl, per, ovf;
  pirf_pkg::pirf_ssp_evt_t ssp;
  pirf_pkg::pirf_ccp_evt_t ccp;
  logic [31:0]             x;
  int                      error_cnt;
  int                      checked;

  // ==========================================================
  // clock and instances
  always #10 i_clock = ~i_clock;

  pirf_periph_model part (.i_go(go), .i_code(code), .i_rx_level(rx), .i_cmp_mode(cm),
    .o_psp_done(psp), .o_conv_done(conv), .o_rx_full(rxf), .o_tx_moved(txm), .o_tx_loaded(txl),
    .o_ssp(ssp), .o_ccp(ccp), .o_period_match(per), .o_overflow(ovf));

  pirf_flag_register dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_bus(bus), .i_psp_done(psp),
    .i_conv_done(conv), .i_rx_full(rxf), .i_tx_moved(txm), .i_tx_loaded(txl), .i_ssp(ssp),
    .i_ccp(ccp), .i_period_match(per), .i_overflow(ovf), .o_rdata(o_rdata), .o_flags(o_flags));

  // ==========================================================
  // reference model
  function automatic logic [7:0] predict(input logic [7:0] f, input pirf_pkg::pirf_bus_req_t b,
                                         input logic g, input logic [3:0] c, input logic m, input logic r);
    logic [7:0]  n;
    logic [12:0] ev;
    ev = g ? (13'h0001 << c) : 13'h0000;
    n = f;
    if (b.wr && b.addr == 8'h0C) n = (n & 8'h30) | (b.wdata & 8'hCF);
    n[7] = n[7] | ev[0];
    n[6] = n[6] | ev[1];
    if (ev[2]) n[4] = 1'b1;
    else if (ev[3]) n[4] = 1'b0;
    n[3] = n[3] | (|ev[8:4]);
    n[2] = n[2] | (m ? ev[10] : ev[9]);
    n[1] = n[1] | ev[11];
    n[0] = n[0] | ev[12];
    n[5] = r;
    return n;
  endfunction : predict

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  always @(posedge i_clock) begin
    started <= 1'b1;
    if (!i_rstn) begin
      exp_flags <= 8'h00;
      exp_rdata <= 8'h00;
    end else begin
      exp_flags <= predict(exp_flags, bus, go, code, cm, rx);
      exp_rdata <= (bus.rd && bus.addr == 8'h0C) ? exp_flags : 8'h00;
    end
  end

  always @(negedge i_clock) begin
    if (started) begin
      checked = checked + 2;
      if (o_flags !== exp_flags) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t flags %h want %h", $time, o_flags, exp_flags);
      end
      if (o_rdata !== exp_rdata) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t read %h want %h", $time, o_rdata, exp_rdata);
      end
    end
  end

  // ==========================================================
  // stimulus
  task automatic run(input int n);
    repeat (n) begin
      @(posedge i_clock);
      x = xs(x);
      go <= x[0] & x[1];
      code <= 4'(x[7:4] % 13);
      if (x[23:20] == 4'h0) rx <= ~rx;
      if (x[27:24] == 4'h0) cm <= ~cm;
      bus.wr <= x[17:16] == 2'b00;
      bus.rd <= x[17:16] == 2'b01;
      bus.addr <= x[18] ? 8'h0C : x[31:24];
      bus.wdata <= x[19] ? 8'h00 : x[15:8];
    end
    @(posedge i_clock);
    go <= 1'b0;
    bus <= '0;
  endtask : run

  // one hand-written cycle on the flag register address
  task automatic step(input logic g, input logic [3:0] c, input logic w, input logic r, input logic [7:0] d);
    @(posedge i_clock);
    go <= g;
    code <= c;
    bus.wr <= w;
    bus.rd <= r;
    bus.addr <= 8'h0C;
    bus.wdata <= d;
  endtask : step

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial begin
    i_clock = 1'b0;
    i_rstn = 1'b0;
    go = 1'b0;
    code = 4'h0;
    rx = 1'b0;
    cm = 1'b0;
    bus = '0;
    started = 1'b0;
    x = 32'h00000040;
    error_cnt = 0;
    checked = 0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    $display("test reset done");
    step(1'b1, 4'hC, 1'b1, 1'b0, 8'h00);
    step(1'b1, 4'h0, 1'b1, 1'b0, 8'h00);
    step(1'b1, 4'h1, 1'b0, 1'b1, 8'h00);
    step(1'b1, 4'h2, 1'b1, 1'b0, 8'hFF);
    step(1'b1, 4'h3, 1'b1, 1'b0, 8'h00);
    step(1'b1, 4'hA, 1'b0, 1'b1, 8'h00);
    step(1'b0, 4'h0, 1'b0, 1'b1, 8'h00);
    step(1'b0, 4'h0, 1'b0, 1'b0, 8'h00);
    $display("test corners done");
    run(1500);
    $display("test random first half done");
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    run(1500);
    $display("test random after second reset done");
    wrap_up();
  end
endmodule : pirf_flag_register_bench
`default_nettype wire
